// *** shared/anp_pkg.sv ***
package anp_pkg;

  // Clause 45 addressing over APB: byte address = {devad, register index, 2'b00}.
  localparam int             ANP_DEVAD_LSB      = 18;
  localparam int             ANP_IDX_LSB        = 2;
  localparam logic [4:0]     ANP_DEVAD          = 5'h07;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [15:0]    ANP_IDX_PAGE_LOW   = 16'h020b;
  localparam logic [15:0]    ANP_IDX_PAGE_MID   = 16'h020c;
  localparam logic [15:0]    ANP_IDX_PAGE_HIGH  = 16'h020d;
  localparam logic [15:0]    ANP_IDX_ADVERT     = 16'h020e;
  localparam logic [15:0]    ANP_IDX_PARTNER    = 16'h020f;
  localparam logic [15:0]    ANP_IDX_FORCED     = 16'h8000;
  localparam logic [15:0]    ANP_IDX_EXTRA      = 16'h8001;
  localparam logic [15:0]    ANP_IDX_IRQ_STATUS = 16'h8010;
  localparam logic [15:0]    ANP_IDX_IRQ_MASK   = 16'h8011;

  // Field positions.
  localparam int             ANP_ADV_LONG_BIT   = 15;
  localparam int             ANP_ADV_EEE_BIT    = 14;
  localparam int             ANP_ADV_HI_ABL_BIT = 13;
  localparam int             ANP_ADV_HI_REQ_BIT = 12;
  localparam int             ANP_FORCED_BIT     = 0;
  localparam int             ANP_EXTRA_PAGE_BIT = 10;
  localparam int             ANP_EXTRA_INC_BIT  = 9;

  // Values after reset.
  localparam logic [15:0]    ANP_ADVERT_RESET   = 16'h8000;
  localparam logic [15:0]    ANP_WORD_RESET     = 16'h0000;
  localparam logic           ANP_LONG_RESET     = 1'h1;

  // Interrupt sources, one bit each in status and mask.
  localparam int             ANP_IRQ_WIDTH      = 3;
  localparam int             ANP_IRQ_PAGE       = 0;
  localparam int             ANP_IRQ_INCOMPAT   = 1;
  localparam int             ANP_IRQ_DONE       = 2;
  localparam logic [2:0]     ANP_IRQ_RESET      = 3'h0;

  // Cycles after reset release before the synchronised straps are trusted.
  localparam logic [1:0]     ANP_STRAP_SETTLE   = 2'h2;

  // Transmit level resolution codes.
  localparam logic [1:0]     ANP_TXLVL_NOT_RUN  = 2'h0;
  localparam logic [1:0]     ANP_TXLVL_LOW      = 2'h2;
  localparam logic [1:0]     ANP_TXLVL_HIGH     = 2'h3;

  // Leader/follower resolution codes.
  localparam logic [1:0]     ANP_LF_NOT_RUN     = 2'h0;
  localparam logic [1:0]     ANP_LF_FAULT       = 2'h1;
  localparam logic [1:0]     ANP_LF_FOLLOWER    = 2'h2;
  localparam logic [1:0]     ANP_LF_LEADER      = 2'h3;

  // Common technology codes.
  localparam logic [3:0]     ANP_TECH_NOT_RUN   = 4'h0;
  localparam logic [3:0]     ANP_TECH_LONG_10M  = 4'h1;

  typedef struct packed {
    logic partner_long_reach_ability;
    logic partner_energy_saving_ability;
    logic partner_high_level_ability;
    logic partner_high_level_request;
    logic partner_short_reach_full_duplex;
    logic partner_short_reach_half_duplex;
  } anp_partner_t;

  typedef struct packed {
    logic local_long_reach_ability;
    logic local_high_level_ability;
    logic local_high_level_request;
  } anp_local_t;

  typedef struct packed {
    logic       good_check_entry;
    logic       incompatible_link;
    logic [1:0] tx_level_resolution;
    logic [1:0] leader_follower_resolution;
    logic [3:0] common_technology_result;
    logic       negotiation_done;
  } anp_result_t;

  typedef enum logic [1:0] {
    ANP_ST_IDLE   = 2'b01,
    ANP_ST_ACCESS = 2'b10
  } anp_state_t;

endpackage : anp_pkg

// *** verilog/anp_sticky.sv ***
`timescale 1ns/1ns
module anp_sticky #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clear_bits,
  output logic      [WIDTH-1:0] flags
);
  import anp_pkg::*;

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // A set in the same cycle as its clear wins, so no event is lost.
  assign flags_next = set_bits | (flags_reg & ~clear_bits);
  assign flags      = flags_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : anp_sticky

// *** verilog/anp_regs.sv ***
`timescale 1ns/1ns
// Operation
// - All registers sit in management device 7 at indices 0x020b-0x020f, 0x8000-0x8001 and 0x8010-0x8011.
// - Reading the partner page low word captures the partner middle and high words.
// - Middle and high words read back the captured snapshot, read-only, reset zero.
// - Advert bit 15 is a read/write alias of local long-reach ability, reset one.
// - Advert bit 14 mirrors the local energy-saving ability, read-only, reset zero.
// - Advert bits 13 and 12 alias the local high-level ability and request, reset from straps.
// - Partner status bits 15 to 12 mirror the partner long-reach, energy, high-level bits.
// - Partner status bits 7 and 6 mirror short-reach duplex abilities, the rest reads zero.
// - Forced mode engages only with negotiation disabled and the forced bit set.
// - Extra status bit 10 latches on a partner page request until software reads it.
// - Extra status bit 9 takes the incompatible-link result on entry to good-check.
// - Extra status bits 8:7 report the transmit level resolution.
// - Extra status bits 6:5 report the leader/follower resolution.
// - Extra status bits 4:1 report the common technology result.
// - Extra status bit 0 shows that negotiation transmission is complete.
module anp_regs (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  input  wire logic [15:0]          partner_next_page_low,
  input  wire logic [15:0]          partner_page_code_one,
  input  wire logic [15:0]          partner_page_code_two,
  input  wire logic                 partner_page_request,
  input  wire anp_pkg::anp_partner_t partner_ability,
  input  wire logic                 local_energy_saving_ability,
  input  wire logic                 alias_write,
  input  wire anp_pkg::anp_local_t  alias_data,
  input  wire anp_pkg::anp_result_t result,
  input  wire logic                 negotiation_enable,
  input  wire logic                 high_level_ability_strap,
  input  wire logic                 high_level_request_strap,
  output anp_pkg::anp_local_t       local_ability,
  output logic                      forced_mode_engaged
);
  import anp_pkg::*;

  anp_state_t      state_reg;
  anp_state_t      state_next;
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;
  logic            irq_reg;
  logic [15:0]     page_mid_reg;
  logic [15:0]     page_high_reg;
  anp_local_t      local_reg;
  anp_local_t      local_next;
  logic            forced_reg;
  logic            engaged_reg;
  logic            inc_link_reg;
  logic [1:0]      txlvl_reg;
  logic [1:0]      lf_reg;
  logic [3:0]      tech_reg;
  logic            done_reg;
  logic            done_prev_reg;
  logic            eee_reg;
  anp_partner_t    partner_reg;
  logic [2:0]      irq_mask_reg;
  logic [1:0]      strap_meta_reg;
  logic [1:0]      strap_sync_reg;
  logic [1:0]      strap_cnt_reg;
  logic            strap_done_reg;

  // Bus decode.
  logic            dev_hit;
  logic [15:0]     idx;
  logic            hit_low;
  logic            hit_mid;
  logic            hit_high;
  logic            hit_advert;
  logic            hit_partner;
  logic            hit_forced;
  logic            hit_extra;
  logic            hit_irq_status;
  logic            hit_irq_mask;
  logic            mapped;
  logic            setup;
  logic            finish;
  logic            wr_done;
  logic            rd_done;
  logic [31:0]     rd_word;
  logic [15:0]     advert_word;
  logic [15:0]     partner_word;
  logic [15:0]     extra_word;
  logic [2:0]      irq_flags;
  logic [2:0]      irq_set;
  logic [2:0]      irq_clear;
  logic            page_flag;
  logic            page_clear;
  logic            strap_load;

  assign dev_hit        = (paddr[ANP_DEVAD_LSB +: 5] == ANP_DEVAD)
                          && (paddr[31:ANP_DEVAD_LSB+5] == '0);
  assign idx            = paddr[ANP_IDX_LSB +: 16];
  assign hit_low        = dev_hit && (idx == ANP_IDX_PAGE_LOW);
  assign hit_mid        = dev_hit && (idx == ANP_IDX_PAGE_MID);
  assign hit_high       = dev_hit && (idx == ANP_IDX_PAGE_HIGH);
  assign hit_advert     = dev_hit && (idx == ANP_IDX_ADVERT);
  assign hit_partner    = dev_hit && (idx == ANP_IDX_PARTNER);
  assign hit_forced     = dev_hit && (idx == ANP_IDX_FORCED);
  assign hit_extra      = dev_hit && (idx == ANP_IDX_EXTRA);
  assign hit_irq_status = dev_hit && (idx == ANP_IDX_IRQ_STATUS);
  assign hit_irq_mask   = dev_hit && (idx == ANP_IDX_IRQ_MASK);
  assign mapped         = hit_low | hit_mid | hit_high | hit_advert | hit_partner
                          | hit_forced | hit_extra | hit_irq_status | hit_irq_mask;

  assign setup   = (state_reg == ANP_ST_IDLE) && psel && !penable;
  assign finish  = (state_reg == ANP_ST_ACCESS) && psel && penable && pready_reg;
  // Side effects need a mapped address; an errored access changes nothing.
  assign wr_done = finish && pwrite && mapped;
  assign rd_done = finish && !pwrite && mapped;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ANP_ST_IDLE: begin
        if (setup) begin
          state_next = ANP_ST_ACCESS;
        end
      end
      ANP_ST_ACCESS: begin
        if (finish) begin
          state_next = ANP_ST_IDLE;
        end
      end
      default: begin
        state_next = ANP_ST_IDLE;
      end
    endcase
  end

  // Read data assembly.
  assign advert_word  = {local_reg.local_long_reach_ability, eee_reg,
                         local_reg.local_high_level_ability,
                         local_reg.local_high_level_request, 12'h000};
  assign partner_word = {partner_reg.partner_long_reach_ability,
                         partner_reg.partner_energy_saving_ability,
                         partner_reg.partner_high_level_ability,
                         partner_reg.partner_high_level_request, 4'h0,
                         partner_reg.partner_short_reach_full_duplex,
                         partner_reg.partner_short_reach_half_duplex, 6'h00};
  assign extra_word   = {5'h00, page_flag, inc_link_reg, txlvl_reg,
                         lf_reg, tech_reg, done_reg};

  assign rd_word = hit_low        ? {16'h0000, partner_next_page_low} :
                   hit_mid        ? {16'h0000, page_mid_reg} :
                   hit_high       ? {16'h0000, page_high_reg} :
                   hit_advert     ? {16'h0000, advert_word} :
                   hit_partner    ? {16'h0000, partner_word} :
                   hit_forced     ? {31'h00000000, forced_reg} :
                   hit_extra      ? {16'h0000, extra_word} :
                   hit_irq_status ? {29'h00000000, irq_flags} :
                   hit_irq_mask   ? {29'h00000000, irq_mask_reg} :
                                    32'h00000000;

  // Only a flag that was reported in the read data is cleared by that read.
  assign page_clear = rd_done && hit_extra && prdata_reg[ANP_EXTRA_PAGE_BIT];

  anp_sticky #(
    .WIDTH (1)
  ) u_page_flag (
    .pclk       (pclk),
    .presetn    (presetn),
    .set_bits   (partner_page_request),
    .clear_bits (page_clear),
    .flags      (page_flag)
  );

  assign irq_set[ANP_IRQ_PAGE]     = partner_page_request;
  assign irq_set[ANP_IRQ_INCOMPAT] = result.good_check_entry && result.incompatible_link;
  assign irq_set[ANP_IRQ_DONE]     = done_reg && !done_prev_reg;
  assign irq_clear = (wr_done && hit_irq_status) ? pwdata[ANP_IRQ_WIDTH-1:0] : 3'h0;

  anp_sticky #(
    .WIDTH (ANP_IRQ_WIDTH)
  ) u_irq_flags (
    .pclk       (pclk),
    .presetn    (presetn),
    .set_bits   (irq_set),
    .clear_bits (irq_clear),
    .flags      (irq_flags)
  );

  // Straps are caught once, after reset release, when the synchroniser has settled.
  assign strap_load = !strap_done_reg && (strap_cnt_reg == ANP_STRAP_SETTLE);

  always_comb begin
    local_next = local_reg;
    if (strap_load) begin
      local_next.local_high_level_ability = strap_sync_reg[1];
      local_next.local_high_level_request = strap_sync_reg[0];
    end
    // The other alias location writes first; a bus write in the same cycle wins.
    if (alias_write) begin
      local_next = alias_data;
    end
    if (wr_done && hit_advert) begin
      local_next.local_long_reach_ability = pwdata[ANP_ADV_LONG_BIT];
      local_next.local_high_level_ability = pwdata[ANP_ADV_HI_ABL_BIT];
      local_next.local_high_level_request = pwdata[ANP_ADV_HI_REQ_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ANP_ST_IDLE;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_word;
        pready_reg  <= 1'h1;
        pslverr_reg <= !mapped;
      end else if (finish) begin
        prdata_reg  <= 32'h00000000;
        pready_reg  <= 1'h0;
        pslverr_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_mid_reg  <= ANP_WORD_RESET;
      page_high_reg <= ANP_WORD_RESET;
    end else if (rd_done && hit_low) begin
      page_mid_reg  <= partner_page_code_one;
      page_high_reg <= partner_page_code_two;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_reg <= '{local_long_reach_ability: ANP_LONG_RESET,
                     local_high_level_ability: 1'h0,
                     local_high_level_request: 1'h0};
    end else begin
      local_reg <= local_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'h0;
    end else begin
      strap_meta_reg <= {high_level_ability_strap, high_level_request_strap};
      strap_sync_reg <= strap_meta_reg;
      if (strap_cnt_reg != ANP_STRAP_SETTLE) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_load) begin
        strap_done_reg <= 1'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_reg   <= 1'h0;
      engaged_reg  <= 1'h0;
      irq_mask_reg <= ANP_IRQ_RESET;
      irq_reg      <= 1'h0;
    end else begin
      if (wr_done && hit_forced) begin
        forced_reg <= pwdata[ANP_FORCED_BIT];
      end
      engaged_reg <= !negotiation_enable && forced_reg;
      if (wr_done && hit_irq_mask) begin
        irq_mask_reg <= pwdata[ANP_IRQ_WIDTH-1:0];
      end
      irq_reg <= |(irq_flags & irq_mask_reg);
    end
  end

  // Mirrors are registered so every read sees a value sampled on one edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_link_reg  <= 1'h0;
      txlvl_reg     <= ANP_TXLVL_NOT_RUN;
      lf_reg        <= ANP_LF_NOT_RUN;
      tech_reg      <= ANP_TECH_NOT_RUN;
      done_reg      <= 1'h0;
      done_prev_reg <= 1'h0;
      eee_reg       <= 1'h0;
      partner_reg   <= '0;
    end else begin
      if (result.good_check_entry) begin
        inc_link_reg <= result.incompatible_link;
      end
      txlvl_reg     <= result.tx_level_resolution;
      lf_reg        <= result.leader_follower_resolution;
      tech_reg      <= result.common_technology_result;
      done_reg      <= result.negotiation_done;
      done_prev_reg <= done_reg;
      eee_reg       <= local_energy_saving_ability;
      partner_reg   <= partner_ability;
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign irq                 = irq_reg;
  assign local_ability       = local_reg;
  assign forced_mode_engaged = engaged_reg;

endmodule : anp_regs

// *** sim/anp_regs_assertions.sv ***
`timescale 1ns/1ns
module anp_regs_assertions (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire anp_pkg::anp_partner_t partner_ability,
  input wire logic                  local_energy_saving_ability,
  input wire logic                  alias_write,
  input wire anp_pkg::anp_local_t   alias_data,
  input wire logic                  negotiation_enable,
  input wire anp_pkg::anp_local_t   local_ability,
  input wire logic                  forced_mode_engaged
);
  import anp_pkg::*;
  logic        in_dev;
  logic        setup;
  logic        setup_rd;
  logic [15:0] idx;
  assign in_dev   = paddr[31:18] == {9'h0, ANP_DEVAD};
  assign idx      = paddr[17:2];
  assign setup    = psel && !penable;
  assign setup_rd = setup && !pwrite && in_dev;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The enable must stay low across the write and the following cycle.
  sequence s_forced_write;
    psel && penable && pready && pwrite && in_dev && idx == ANP_IDX_FORCED
      && !negotiation_enable ##1 !negotiation_enable;
  endsequence
  chk_ready_after_setup: assert property (setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  chk_unmapped_error: assert property (setup && !in_dev |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside a transfer");
  chk_partner_mirror: assert property (
    setup_rd && idx == ANP_IDX_PARTNER && $stable(partner_ability) |=>
      prdata == {16'h0, $past(partner_ability[5:2]), 4'h0, $past(partner_ability[1:0]), 6'h0})
    else $error("partner status read wrong");
  chk_eee_mirror: assert property (
    setup_rd && idx == ANP_IDX_ADVERT && $stable(local_energy_saving_ability) |=>
      prdata[14] == $past(local_energy_saving_ability) && prdata[11:0] == 12'h0)
    else $error("advert energy bit wrong");
  chk_alias_load: assert property (
    alias_write && !(psel && penable && pwrite) |=> local_ability == $past(alias_data))
    else $error("alias write not taken");
  chk_forced_off: assert property (negotiation_enable |=> !forced_mode_engaged)
    else $error("forced mode with negotiation on");
  chk_forced_write: assert property (
    s_forced_write |=> forced_mode_engaged == $past(pwdata[0], 2))
    else $error("forced mode not following write");
endmodule : anp_regs_assertions

// *** sim/anp_neg_model.sv ***
`timescale 1ns/1ns
module anp_neg_model (
  input  wire logic             pclk,
  output logic [15:0]           partner_next_page_low,
  output logic [15:0]           partner_page_code_one,
  output logic [15:0]           partner_page_code_two,
  output logic                  partner_page_request,
  output anp_pkg::anp_partner_t partner_ability,
  output logic                  local_energy_saving_ability,
  output logic                  alias_write,
  output anp_pkg::anp_local_t   alias_data,
  output anp_pkg::anp_result_t  result
);
  import anp_pkg::*;
  initial begin
    partner_next_page_low       = 16'h0;
    partner_page_code_one       = 16'h0;
    partner_page_code_two       = 16'h0;
    partner_page_request        = 1'b0;
    partner_ability             = '0;
    local_energy_saving_ability = 1'b0;
    alias_write                 = 1'b0;
    alias_data                  = '0;
    result                      = '0;
  end
  task automatic set_page(input logic [15:0] lo, input logic [15:0] one,
                          input logic [15:0] two);
    @(posedge pclk);
    partner_next_page_low <= lo;
    partner_page_code_one <= one;
    partner_page_code_two <= two;
  endtask : set_page
  task automatic set_abil(input anp_partner_t a, input logic eee);
    @(posedge pclk);
    partner_ability             <= a;
    local_energy_saving_ability <= eee;
  endtask : set_abil
  task automatic pulse_req();
    @(posedge pclk);
    partner_page_request <= 1'b1;
    @(posedge pclk);
    partner_page_request <= 1'b0;
  endtask : pulse_req
  // Results stay as levels; only the good-check entry is a one-cycle pulse.
  task automatic set_res(input anp_result_t r);
    @(posedge pclk);
    result <= r;
    @(posedge pclk);
    result.good_check_entry <= 1'b0;
  endtask : set_res
  // Data is inverted once the strobe drops so a stale value is never mistaken for a load.
  task automatic set_alias(input anp_local_t a);
    @(posedge pclk);
    alias_write <= 1'b1;
    alias_data  <= a;
    @(posedge pclk);
    alias_write <= 1'b0;
    alias_data  <= ~a;
  endtask : set_alias
endmodule : anp_neg_model

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import anp_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic [15:0]  partner_next_page_low;
  logic [15:0]  partner_page_code_one;
  logic [15:0]  partner_page_code_two;
  logic         partner_page_request;
  anp_partner_t partner_ability;
  logic         local_energy_saving_ability;
  logic         alias_write;
  anp_local_t   alias_data;
  anp_result_t  result;
  logic         negotiation_enable;
  logic         high_level_ability_strap;
  logic         high_level_request_strap;
  anp_local_t   local_ability;
  logic         forced_mode_engaged;
  int           fails;
  int           tests_run;
  logic [31:0]  d;
  logic         e;
  anp_regs anp_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .partner_next_page_low, .partner_page_code_one,
    .partner_page_code_two, .partner_page_request, .partner_ability,
    .local_energy_saving_ability, .alias_write, .alias_data, .result, .negotiation_enable,
    .high_level_ability_strap, .high_level_request_strap, .local_ability,
    .forced_mode_engaged);
  anp_neg_model anp_neg_model_inst (.pclk, .partner_next_page_low, .partner_page_code_one,
    .partner_page_code_two, .partner_page_request, .partner_ability,
    .local_energy_saving_ability, .alias_write, .alias_data, .result);
  task automatic end_sim();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [4:0] dv, input logic [15:0] ix,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {9'h0, dv, ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] ix, input logic [31:0] ex);
    apb(1'b0, ANP_DEVAD, ix, 32'h0);
    chk32(d, ex);
  endtask : rd
  task automatic wr(input logic [15:0] ix, input logic [31:0] wd);
    apb(1'b1, ANP_DEVAD, ix, wd);
  endtask : wr
  task automatic t_reset();
    rd(ANP_IDX_PAGE_MID, 32'h0);
    rd(ANP_IDX_PAGE_HIGH, 32'h0);
    rd(ANP_IDX_ADVERT, 32'ha000);
    rd(ANP_IDX_PARTNER, 32'h0);
    rd(ANP_IDX_FORCED, 32'h0);
    rd(ANP_IDX_EXTRA, 32'h0);
    chk32({29'h0, local_ability}, 32'h6);
    apb(1'b0, ANP_DEVAD, 16'h8002, 32'h0);
    chk1(e, 1'b1);
    apb(1'b0, 5'h06, ANP_IDX_EXTRA, 32'h0);
    chk1(e, 1'b1);
  endtask : t_reset
  task automatic t_capture();
    anp_neg_model_inst.set_page(16'h1234, 16'h5a5a, 16'ha5a5);
    rd(ANP_IDX_PAGE_LOW, 32'h1234);
    anp_neg_model_inst.set_page(16'h0f0f, 16'hffff, 16'h0001);
    rd(ANP_IDX_PAGE_MID, 32'h5a5a);
    rd(ANP_IDX_PAGE_HIGH, 32'ha5a5);
    wr(ANP_IDX_PAGE_MID, 32'h0);
    rd(ANP_IDX_PAGE_MID, 32'h5a5a);
    rd(ANP_IDX_PAGE_LOW, 32'h0f0f);
    rd(ANP_IDX_PAGE_HIGH, 32'h0001);
  endtask : t_capture
  task automatic t_advert();
    anp_neg_model_inst.set_abil(6'h2a, 1'b1);
    wr(ANP_IDX_ADVERT, 32'hffff0fff);
    rd(ANP_IDX_ADVERT, 32'h4000);
    chk32({29'h0, local_ability}, 32'h0);
    anp_neg_model_inst.set_alias(3'h7);
    rd(ANP_IDX_ADVERT, 32'hf000);
    rd(ANP_IDX_PARTNER, 32'ha080);
    anp_neg_model_inst.set_abil(6'h15, 1'b1);
    wr(ANP_IDX_PARTNER, 32'hffff);
    rd(ANP_IDX_PARTNER, 32'h5040);
  endtask : t_advert
  task automatic t_forced();
    wr(ANP_IDX_FORCED, 32'hffff);
    rd(ANP_IDX_FORCED, 32'h1);
    repeat (2) @(posedge pclk);
    chk1(forced_mode_engaged, 1'b0);
    negotiation_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    chk1(forced_mode_engaged, 1'b1);
    wr(ANP_IDX_FORCED, 32'h0);
    repeat (3) @(posedge pclk);
    chk1(forced_mode_engaged, 1'b0);
  endtask : t_forced
  task automatic t_extra();
    anp_result_t r;
    logic [1:0]  lvl [4];
    lvl = '{2'h0, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++) begin
      r = '{1'b1, i[1], lvl[i], i[1:0], {3'h0, i[0]}, i[0]};
      anp_neg_model_inst.set_res(r);
      rd(ANP_IDX_EXTRA, {22'h0, r[9:0]});
    end
    anp_neg_model_inst.set_res('{1'b0, 1'b0, 2'h2, 2'h1, 4'h1, 1'b0});
    rd(ANP_IDX_EXTRA, 32'h322);
    anp_neg_model_inst.pulse_req();
    rd(ANP_IDX_EXTRA, 32'h722);
    rd(ANP_IDX_EXTRA, 32'h322);
    wr(ANP_IDX_EXTRA, 32'hffff);
    rd(ANP_IDX_EXTRA, 32'h322);
  endtask : t_extra
  task automatic t_irq();
    rd(ANP_IDX_IRQ_STATUS, 32'h7);
    wr(ANP_IDX_IRQ_STATUS, 32'h7);
    rd(ANP_IDX_IRQ_STATUS, 32'h0);
    wr(ANP_IDX_IRQ_MASK, 32'h1);
    chk1(irq, 1'b0);
    anp_neg_model_inst.pulse_req();
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b1);
    rd(ANP_IDX_IRQ_STATUS, 32'h1);
    wr(ANP_IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    wr(ANP_IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b1);
    wr(ANP_IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
  endtask : t_irq
  task automatic t_rerun();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ANP_IDX_PAGE_MID, 32'h0);
  endtask : t_rerun
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // The whole sequence needs under two hundred cycles; fifteen times that means a hang.
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    end_sim();
  end
  initial begin
    fails                    = 0;
    tests_run                = 0;
    presetn                  = 1'b0;
    psel                     = 1'b0;
    penable                  = 1'b0;
    pwrite                   = 1'b0;
    paddr                    = 32'h0;
    pwdata                   = 32'h0;
    negotiation_enable       = 1'b1;
    high_level_ability_strap = 1'b1;
    high_level_request_strap = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_capture();
    t_advert();
    t_forced();
    t_extra();
    t_irq();
    t_rerun();
    end_sim();
  end
endmodule : testbench
bind anp_regs anp_regs_assertions anp_regs_assertions_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .partner_ability,
  .local_energy_saving_ability, .alias_write, .alias_data, .negotiation_enable,
  .local_ability, .forced_mode_engaged);
